// ==== design/feo_regs.sv ====
// Purpose: Error status, erase block select and RAM overlay control registers
// Assumes: Power-on reset is aresetn; standby and pin levels synchronous to aclk
// Notes:   Mode-control enables are held in a small register of this block
`timescale 1ns/10ps
`include "feo_defines.svh"

module feo_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        flash_enabled,
    input  wire logic        standby,
    input  wire logic        flash_protect_pin,
    input  wire logic        error_detect,
    input  wire logic [23:0] cpu_addr,
    output logic             program_fault_flag,
    output logic             erase_enable,
    output logic             all_blocks_protected,
    output logic [23:0]      mapped_addr,
    output logic             overlay_hit
);

    feo_pkg::feo_state_type st;
    feo_pkg::feo_state_type next_st;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] feo_ones(input logic [10:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 11; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // Block index that holds an array address; 4'hF when outside the array
    function automatic logic [3:0] feo_block_of(input logic [23:0] a);
        logic [3:0] b;
        if (a < `FEO_B8_BASE) begin
            b = a[15:12];
        end else if (a < `FEO_B9_BASE) begin
            b = 4'h8;
        end else if (a < `FEO_B10_BASE) begin
            b = 4'h9;
        end else if (a <= `FEO_B10_END) begin
            b = 4'hA;
        end else begin
            b = 4'hF;
        end
        return b;
    endfunction

    logic        hw_we;
    logic        clear_sel;
    logic [10:0] sel_all;
    logic        one_sel;
    logic [23:0] win_base;
    logic        in_win;
    logic [3:0]  erase_blk;

    always_comb begin
        hw_we     = ~flash_protect_pin;
        // Select registers held clear whenever writes are not armed
        clear_sel = standby | flash_protect_pin | ~st.software_write_enable | ~flash_enabled;
        sel_all   = {st.sel_high, st.sel_low};
        one_sel   = (feo_ones(sel_all) == 4'h1);
        win_base  = `FEO_OVL_BASE
                  + ({22'h0, st.overlay[1:0]} << `FEO_OVL_STEP_SH);
        in_win    = st.overlay[`FEO_OVL_EN_BIT]
                  && (cpu_addr[23:`FEO_OVL_WIN_SH] == win_base[23:`FEO_OVL_WIN_SH]);
        erase_blk = feo_block_of(cpu_addr);
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [7:0]  a;
        logic [31:0] d;
        logic        wr;
        logic        rd_ok;
        logic [31:0] rv;
        a     = 8'h00;
        d     = 32'h0;
        wr    = 1'b0;
        rd_ok = 1'b1;
        rv    = 32'h0;
        next_st = st;

        // Write address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.have_aw = 1'b1;
            next_st.waddr   = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.have_w = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
            next_st.wready = 1'b0;
        end

        case (st.wstate)
            feo_pkg::FEO_W_IDLE: begin
                if (st.have_aw && st.have_w) begin
                    wr = 1'b1;
                    a  = st.waddr;
                    d  = st.wdata;
                    next_st.have_aw = 1'b0;
                    next_st.have_w  = 1'b0;
                    next_st.bvalid  = 1'b1;
                    next_st.bresp   = `FEO_RESP_OKAY;
                    next_st.wstate  = feo_pkg::FEO_W_RESP;
                    if (a > `FEO_OFF_MODE || a[1:0] != 2'h0) begin
                        next_st.bresp = `FEO_RESP_SLVERR;
                    end
                end
            end
            feo_pkg::FEO_W_RESP: begin
                if (s_axi_bready) begin
                    next_st.bvalid  = 1'b0;
                    next_st.awready = 1'b1;
                    next_st.wready  = 1'b1;
                    next_st.wstate  = feo_pkg::FEO_W_IDLE;
                end
            end
            default: begin
                next_st.wstate = feo_pkg::FEO_W_IDLE;
            end
        endcase

        // Register writes; status has no write path at all
        if (wr && st.wstrb[0]) begin
            case (a)
                `FEO_OFF_SEL_LOW: begin
                    next_st.sel_low = d[7:0];
                end
                `FEO_OFF_SEL_HIGH: begin
                    next_st.sel_high = d[2:0];
                end
                `FEO_OFF_OVERLAY: begin
                    next_st.overlay = d[2:0];
                end
                `FEO_OFF_MODE: begin
                    next_st.software_write_enable = d[`FEO_MODE_SWE_BIT] & hw_we;
                    if (hw_we && st.software_write_enable && one_sel) begin
                        next_st.erase_setup = d[`FEO_MODE_ESU_BIT];
                        // Without setup the start bit keeps its value: the write is refused
                        if (st.erase_setup) begin
                            next_st.erase = d[`FEO_MODE_ERS_BIT];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (!hw_we || standby) begin
            next_st.software_write_enable   = 1'b0;
            next_st.erase_setup   = 1'b0;
            next_st.erase = 1'b0;
        end
        if (clear_sel) begin
            next_st.sel_low  = `FEO_RST_BYTE;
            next_st.sel_high = 3'h0;
        end

        // Fault latches from the detect input; nothing but reset clears it
        if (error_detect) begin
            next_st.fault = 1'b1;
        end

        // Read channel
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end else if (s_axi_arvalid && st.arready) begin
            case (s_axi_araddr)
                `FEO_OFF_STATUS: begin
                    rv[`FEO_FAULT_BIT] = st.fault & flash_enabled;
                end
                `FEO_OFF_SEL_LOW: begin
                    rv[7:0] = flash_enabled ? st.sel_low : 8'h00;
                end
                `FEO_OFF_SEL_HIGH: begin
                    rv[2:0] = flash_enabled ? st.sel_high : 3'h0;
                end
                `FEO_OFF_OVERLAY: begin
                    rv[2:0] = st.overlay;
                end
                `FEO_OFF_MODE: begin
                    rv[2:0] = {st.erase, st.erase_setup, st.software_write_enable};
                end
                default: begin
                    rd_ok = 1'b0;
                end
            endcase
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = rv;
            next_st.rresp   = rd_ok ? `FEO_RESP_OKAY : `FEO_RESP_SLVERR;
        end

        // Outputs to the array and bus fabric
        next_st.all_protect = st.fault | st.overlay[`FEO_OVL_EN_BIT];
        // Erase only for the single selected block and only when unprotected
        next_st.erase_ok = st.erase && one_sel && !next_st.all_protect
                         && erase_blk != 4'hF && sel_all[erase_blk];
        next_st.redirected  = in_win;
        next_st.mapped_addr = in_win
                            ? (`FEO_RAM_BASE | {14'h0, cpu_addr[9:0]})
                            : cpu_addr;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Overlay is reset here only; standby leaves it alone
            st         <= '0;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign s_axi_awready        = st.awready;
    assign s_axi_wready         = st.wready;
    assign s_axi_bvalid         = st.bvalid;
    assign s_axi_bresp          = st.bresp;
    assign s_axi_arready        = st.arready;
    assign s_axi_rvalid         = st.rvalid;
    assign s_axi_rdata          = st.rdata;
    assign s_axi_rresp          = st.rresp;
    assign program_fault_flag   = st.fault;
    assign erase_enable         = st.erase_ok;
    assign all_blocks_protected = st.all_protect;
    assign mapped_addr          = st.mapped_addr;
    assign overlay_hit          = st.redirected;

endmodule

// ==== shared/feo_defines.svh ====
// Purpose: Constants for the flash erase/protect/overlay register block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses inside the block's window
`ifndef FEO_DEFINES_SVH
`define FEO_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define FEO_ADDR_W          8
`define FEO_OFF_STATUS      8'h00
`define FEO_OFF_SEL_LOW     8'h04
`define FEO_OFF_SEL_HIGH    8'h08
`define FEO_OFF_OVERLAY     8'h0C
`define FEO_OFF_MODE        8'h10

// ****************************************
// Fields and reset values
// ****************************************
`define FEO_FAULT_BIT       7
`define FEO_SEL_HIGH_MASK   8'h07
`define FEO_OVL_MASK        16'h0007
`define FEO_OVL_EN_BIT      2
`define FEO_MODE_SWE_BIT    0
`define FEO_MODE_ESU_BIT    1
`define FEO_MODE_ERS_BIT    2
`define FEO_RST_BYTE        8'h00
`define FEO_RST_HALF        16'h0000
`define FEO_RESP_OKAY       2'h0
`define FEO_RESP_SLVERR     2'h2

// ****************************************
// Address map of the array and overlay
// ****************************************
`define FEO_FA_W            24
`define FEO_OVL_BASE        24'h004000
`define FEO_OVL_STEP_SH     12
`define FEO_OVL_WIN_SH      10
`define FEO_RAM_BASE        24'hFFF800
`define FEO_SMALL_SH        12
`define FEO_B8_BASE         24'h008000
`define FEO_B9_BASE         24'h010000
`define FEO_B10_BASE        24'h020000
`define FEO_B10_END         24'h027FFF

`endif

// ==== shared/feo_pkg.sv ====
// Purpose: Types for the flash erase/protect/overlay register block
// Assumes: Used together with feo_defines.svh
// Notes:   Holds types only
package feo_pkg;

    typedef enum logic [1:0] {
        FEO_W_IDLE = 2'b00,
        FEO_W_RESP = 2'b01
    } feo_wstate_type;

    typedef struct packed {
        feo_wstate_type wstate;
        logic           have_aw;
        logic           have_w;
        logic [7:0]     waddr;
        logic [31:0]    wdata;
        logic [3:0]     wstrb;
        logic           awready;
        logic           wready;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        logic           fault;
        logic [7:0]     sel_low;
        logic [2:0]     sel_high;
        logic [2:0]     overlay;
        logic           software_write_enable;
        logic           erase_setup;
        logic           erase;
        logic           erase_ok;
        logic           all_protect;
        logic [23:0]    mapped_addr;
        logic           redirected;
    } feo_state_type;

endpackage

// ==== bench/feo_regs_checker.sv ====
// Purpose: Port assertions for the erase/overlay register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every feo_regs instance
`timescale 1ns/10ps
module feo_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    input wire logic        error_detect,
    input wire logic        flash_enabled,
    input wire logic [23:0] cpu_addr,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        program_fault_flag,
    input wire logic        erase_enable,
    input wire logic        all_blocks_protected,
    input wire logic [23:0] mapped_addr,
    input wire logic        overlay_hit
);
    // ********
    // Properties
    // ********
    logic rd_go;
    assign rd_go = s_axi_arvalid && s_axi_arready && clk_en;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    fault_hold_a: assert property (program_fault_flag |=> program_fault_flag)
        else $error("fault flag cleared without reset");
    fault_set_a: assert property (error_detect && clk_en |=> ##[0:1] program_fault_flag)
        else $error("fault flag not set by error input");
    fault_prot_a: assert property (program_fault_flag |-> ##[0:1] all_blocks_protected)
        else $error("fault does not protect the array");
    // Erase enable is registered in the same cycle as the protect output; the check still waits for two protected samples
    prot_erase_a: assert property ($past(all_blocks_protected) && all_blocks_protected |->
        !erase_enable) else $error("erase enabled while protected");
    hit_ram_a: assert property (overlay_hit |-> mapped_addr[23:10] == 14'h3FFE)
        else $error("overlay access not sent to ram");
    hit_win_a: assert property ($past(clk_en) && overlay_hit |->
        $past(cpu_addr[23:14]) == 10'h001 && $past(cpu_addr[11:10]) == 2'b00
        && mapped_addr[9:0] == $past(cpu_addr[9:0])) else $error("overlay window wrong");
    no_hit_a: assert property ($past(clk_en) && $past(aresetn) && !overlay_hit |->
        mapped_addr == $past(cpu_addr)) else $error("address moved without overlay");
    status_off_a: assert property (rd_go && s_axi_araddr == 8'h00 && !flash_enabled |=>
        s_axi_rdata == 32'h0) else $error("status visible while flash disabled");
    rd_err_a: assert property (rd_go && s_axi_araddr > 8'h10 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    rd_ans_a: assert property (rd_go |=> s_axi_rvalid)
        else $error("read answer late");
    cover property (overlay_hit);
    cover property (erase_enable);
    cover property ($rose(program_fault_flag));
endmodule

bind feo_regs feo_chk i_feo_chk (.aclk, .aresetn, .clk_en, .error_detect, .flash_enabled,
    .cpu_addr, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .program_fault_flag, .erase_enable, .all_blocks_protected, .mapped_addr,
    .overlay_hit);

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for feo_regs
// Assumes: Bench is the AXI4-Lite master and drives all pins
// Notes:   Integer register model compared at every result
`timescale 1ns/10ps
`include "feo_defines.svh"
module tb;
    logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, flash_enabled, standby, flash_protect_pin;
    logic        error_detect, program_fault_flag, erase_enable, all_blocks_protected;
    logic        overlay_hit;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [23:0] cpu_addr, mapped_addr;
    int          fails, n_checks, b, m_low, m_high, m_ovl, m_swe, m_esu, m_ers, m_flt;

    feo_regs i_feo_regs (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .flash_enabled, .standby, .flash_protect_pin, .error_detect, .cpu_addr,
        .program_fault_flag, .erase_enable, .all_blocks_protected, .mapped_addr,
        .overlay_hit);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ********
    // Model and checks
    // ********
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic logic one_sel();
        logic [10:0] s;
        s = {m_high[2:0], m_low[7:0]};
        return $countones(s) == 1;
    endfunction

    function automatic logic [31:0] m_rd(input logic [7:0] ad);
        case (ad)
            `FEO_OFF_STATUS:   return flash_enabled ? m_flt << 7 : 0;
            `FEO_OFF_SEL_LOW:  return m_low;
            `FEO_OFF_SEL_HIGH: return m_high;
            `FEO_OFF_OVERLAY:  return m_ovl;
            `FEO_OFF_MODE:     return m_swe | m_esu << 1 | m_ers << 2;
            default:           return 0;
        endcase
    endfunction

    function automatic void m_wr(input logic [7:0] ad, input logic [31:0] dv);
        logic ok;
        ok = m_swe && !flash_protect_pin && !standby && flash_enabled;
        case (ad)
            `FEO_OFF_SEL_LOW:  if (ok) m_low = dv[7:0];
            `FEO_OFF_SEL_HIGH: if (ok) m_high = dv[2:0];
            `FEO_OFF_OVERLAY:  m_ovl = dv[2:0];
            `FEO_OFF_MODE: if (!flash_protect_pin && m_swe && one_sel()) begin
                if (m_esu) m_ers = dv[2];
                m_esu = dv[1];
            end
            default: ;
        endcase
        if (ad == `FEO_OFF_MODE && !flash_protect_pin) m_swe = dv[0];
        if (!m_swe) m_low = 0;
        if (!m_swe) m_high = 0;
    endfunction

    // ********
    // Bus and pin drivers
    // ********
    task automatic wr(input logic [7:0] ad, input logic [31:0] dv);
        @(posedge aclk);
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", (ad > 8'h10 || ad[1:0] != 2'b00) ? 2'h2 : 2'h0, s_axi_bresp);
        m_wr(ad, dv);
    endtask

    task automatic rd(input logic [7:0] ad);
        @(posedge aclk);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", m_rd(ad), s_axi_rdata);
        chk("rresp", (ad > 8'h10 || ad[1:0] != 2'b00) ? 2'h2 : 2'h0, s_axi_rresp);
    endtask

    // Pin levels: protect pin, standby, flash enabled
    task automatic lvl(input logic p, input logic s, input logic f);
        @(posedge aclk);
        flash_protect_pin <= p;
        standby           <= s;
        flash_enabled     <= f;
        repeat (2) @(posedge aclk);
        if (p || s || !f) {m_low, m_high} = 0;
        if (p || s) {m_swe, m_esu, m_ers} = 0;
    endtask

    task automatic probe(input logic [23:0] ca);
        logic [11:0] s;
        logic        hit;
        int          bk;
        @(posedge aclk);
        cpu_addr <= ca;
        repeat (3) @(posedge aclk);
        s = {1'b0, m_high[2:0], m_low[7:0]};
        bk = ca < 24'h8000 ? ca[14:12] : ca < 24'h10000 ? 8 : ca < 24'h20000 ? 9 :
            ca < 24'h28000 ? 10 : 11;
        hit = m_ovl[2] && ca[23:12] == 12'(4 + m_ovl[1:0]) && ca[11:10] == 2'b00;
        chk("erase_enable", m_ers && one_sel() && !m_flt && !m_ovl[2] && s[bk], erase_enable);
        chk("all_prot", m_flt || m_ovl[2], all_blocks_protected);
        chk("mapped_addr", hit ? {14'h3FFE, ca[9:0]} : ca, mapped_addr);
        chk("overlay_hit", hit, overlay_hit);
        chk("fault_flag", m_flt, program_fault_flag);
    endtask

    function automatic int bbase(input int k);
        return k < 8 ? k * 'h1000 : k == 8 ? 'h8000 : k == 9 ? 'h10000 :
            k == 10 ? 'h20000 : 'h28000;
    endfunction

    // ********
    // Sequence
    // ********
    initial begin
        void'($urandom(44151));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {standby, flash_protect_pin, error_detect, s_axi_awaddr, s_axi_araddr} = 0;
        {s_axi_wdata, cpu_addr, fails, n_checks} = 0;
        {m_low, m_high, m_ovl, m_swe, m_esu, m_ers, m_flt} = 0;
        clk_en = 1'b1;
        flash_enabled = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (b = 0; b <= 16; b += 4) rd(8'(b));
        wr(`FEO_OFF_SEL_LOW, 32'hFF);
        rd(`FEO_OFF_SEL_LOW);
        wr(`FEO_OFF_MODE, 32'h1);
        wr(`FEO_OFF_SEL_HIGH, 32'hFF);
        rd(`FEO_OFF_SEL_HIGH);
        wr(`FEO_OFF_STATUS, 32'hFF);
        rd(`FEO_OFF_STATUS);
        wr(`FEO_OFF_SEL_LOW, 32'h3);
        wr(`FEO_OFF_MODE, 32'h3);
        rd(`FEO_OFF_MODE);
        for (b = 0; b < 11; b++) begin
            lvl(1'b1, 1'b0, 1'b1);
            lvl(1'b0, 1'b0, 1'b1);
            wr(`FEO_OFF_MODE, 32'h1);
            wr(b < 8 ? `FEO_OFF_SEL_LOW : `FEO_OFF_SEL_HIGH, 32'h1 << (b % 8));
            wr(`FEO_OFF_MODE, 32'h3);
            wr(`FEO_OFF_MODE, 32'h7);
            rd(`FEO_OFF_MODE);
            probe(24'(bbase(b) + $urandom % (bbase(b + 1) - bbase(b))));
            probe(24'(bbase((b + 1) % 11)));
        end
        for (b = 0; b < 4; b++) begin
            wr(`FEO_OFF_OVERLAY, 32'(4 + b));
            rd(`FEO_OFF_OVERLAY);
            probe(24'('h4000 + b * 'h1000 + $urandom % 'h400));
            probe(24'('h4400 + b * 'h1000));
        end
        wr(`FEO_OFF_OVERLAY, 32'hFFFB);
        rd(`FEO_OFF_OVERLAY);
        probe(24'h007010);
        wr(`FEO_OFF_OVERLAY, 32'h6);
        lvl(1'b0, 1'b1, 1'b1);
        rd(`FEO_OFF_SEL_HIGH);
        rd(`FEO_OFF_OVERLAY);
        // Mode write made while standby still holds, so the select write meets both unarmed writes and disabled flash
        wr(`FEO_OFF_MODE, 32'h1);
        lvl(1'b0, 1'b0, 1'b0);
        wr(`FEO_OFF_SEL_LOW, 32'h1);
        rd(`FEO_OFF_SEL_LOW);
        lvl(1'b0, 1'b0, 1'b1);
        wr(`FEO_OFF_OVERLAY, 32'h0);
        wr(`FEO_OFF_MODE, 32'h1);
        wr(`FEO_OFF_SEL_LOW, 32'h1);
        wr(`FEO_OFF_MODE, 32'h3);
        wr(`FEO_OFF_MODE, 32'h7);
        probe(24'($urandom % 'h1000));
        // Frozen clock enable must swallow an error pulse
        @(posedge aclk);
        clk_en       <= 1'b0;
        error_detect <= 1'b1;
        repeat (2) @(posedge aclk);
        clk_en       <= 1'b1;
        error_detect <= 1'b0;
        probe(24'h000200);
        @(posedge aclk);
        error_detect <= 1'b1;
        @(posedge aclk);
        error_detect <= 1'b0;
        m_flt = 1;
        probe(24'h000100);
        wr(`FEO_OFF_STATUS, 32'h0);
        rd(`FEO_OFF_STATUS);
        lvl(1'b0, 1'b0, 1'b0);
        rd(`FEO_OFF_STATUS);
        lvl(1'b0, 1'b0, 1'b1);
        rd(8'h14);
        wr(8'h20, 32'h1);
        summarize();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (30000) @(posedge aclk);
        fails++;
        summarize();
    end
endmodule
